// ---- verilog/dram_ctl_pkg.sv ----
// constants, encodings and register map of the training and calibration host
package dram_ctl_pkg;
   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LAT  = 8'h04;
   localparam logic [7:0] OFF_SKEW = 8'h08;
   localparam logic [7:0] OFF_TWIN = 8'h0C;
   localparam logic [7:0] OFF_ZQT  = 8'h10;
   localparam logic [7:0] OFF_POLL = 8'h14;
   localparam logic [7:0] OFF_CMD  = 8'h18;
   localparam logic [7:0] OFF_RAW  = 8'h1C;
   localparam logic [7:0] OFF_STAT = 8'h20;
   // values after reset
   localparam logic [31:0] RST_CTRL = 32'h0000_0001;
   localparam logic [31:0] RST_LAT  = 32'h0808_080E;
   localparam logic [31:0] RST_SKEW = 32'h0104_2111;
   localparam logic [31:0] RST_TWIN = 32'h0000_080C;
   localparam logic [31:0] RST_ZQT  = 32'h0008_00C8;
   localparam logic [31:0] RST_POLL = 32'h0000_0000;
   // field positions
   localparam int CTRL_CKE = 0;      // clock enable level driven out
   localparam int CTRL_ODT_LSB = 2;  // copy of DQ ODT code, 3 bits
   localparam int LAT_RL_LSB = 0;    // read latency, 6 bits
   localparam int LAT_WL_LSB = 8;    // write latency, 6 bits
   localparam int LAT_BL2_LSB = 16;  // half burst length, 5 bits
   localparam int LAT_CCD_LSB = 24;  // tCCD in cycles, 5 bits
   localparam int SK_DQSS_LSB = 0;   // rounded tDQSS max, 4 bits
   localparam int SK_DQSCK_LSB = 4;  // rounded tDQSCK max, 4 bits
   localparam int SK_RPST_LSB = 8;   // rounded-down tRPST, 4 bits
   localparam int SK_WPRE_LSB = 12;  // tWPRE, 4 bits
   localparam int SK_ODTL_LSB = 16;  // ODTLon, 6 bits
   localparam int SK_ODTN_LSB = 24;  // rounded tODTon min, 4 bits
   localparam int TW_T75_LSB = 0;    // rounded 7.5 ns in cycles, 8 bits
   localparam int TW_WTR_LSB = 8;    // rounded tWTR in cycles, 8 bits
   localparam int ZQ_CAL_LSB = 0;    // tZQCAL in cycles, 16 bits
   localparam int ZQ_LAT_LSB = 16;   // tZQLAT in cycles, 16 bits
   localparam int CMD_CLS_LSB = 0;   // command class, 4 bits
   localparam int CMD_TRAIN = 4;     // MRW touches training parameters
   localparam int CMD_IOCAL = 5;     // MRW touches I/O calibration fields
   localparam int CMD_SHORT = 6;     // generic command of two edges only
   localparam int SB_BUSY = 0;
   localparam int SB_REFUSED = 1;
   localparam int SB_UNDEF = 2;
   localparam int SB_POLL = 3;
   localparam int SB_ZQRUN = 4;
   localparam int SB_ARMED = 5;
   localparam int SB_WRCNT_LSB = 8;
   localparam int SB_RDPTR_LSB = 12;
   // multi-purpose operands and fixed CA words
   localparam logic [6:0] OP_RDFIFO  = 7'h41;
   localparam logic [6:0] OP_RDDQ    = 7'h43;
   localparam logic [6:0] OP_WRFIFO  = 7'h47;
   localparam logic [6:0] OP_ZQSTART = 7'h4F;
   localparam logic [6:0] OP_ZQLATCH = 7'h51;
   localparam logic [5:0] CAS2_R1    = 6'h12;
   localparam logic [5:0] CAS2_OPS   = 6'h00;
   // counts
   localparam logic [2:0] FIFO_DEPTH = 3'h5;
   localparam logic [9:0] MIN_8NCK   = 10'h008;
   localparam int TIMER_W = 16;
   localparam int POLL_W = 32;
   // command classes written by software
   typedef enum logic [3:0] {
      CLS_GEN = 4'b0000, CLS_WR = 4'b0001, CLS_MWR = 4'b0010,
      CLS_RD = 4'b0011, CLS_MRR = 4'b0100, CLS_WRFIFO = 4'b0101,
      CLS_RDFIFO = 4'b0110, CLS_RDDQ = 4'b0111, CLS_MRW = 4'b1000,
      CLS_ZQSTART = 4'b1001, CLS_ZQLATCH = 4'b1010
   } cmd_class_t;
   // spacing groups of the data-moving commands
   typedef enum logic [2:0] {
      G_NONE = 3'b000, G_WR = 3'b001, G_RD = 3'b010,
      G_WF = 3'b011, G_RF = 3'b100, G_RDQ = 3'b101
   } grp_t;
   // sequencer states
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_WAIT = 2'b01, S_SEND = 2'b10
   } state_t;
endpackage

// ---- verilog/gap_timer.sv ----
// saturating cycle counter that measures time since its last restart
`timescale 1ns/10ps
module gap_timer #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             restart,
   output logic [WIDTH-1:0]      elapsed_q
);
   // reset reads as long ago, so nothing is held off after start-up
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         elapsed_q <= '1;
      end else if (restart) begin
         elapsed_q <= '0;
      end else if (~&elapsed_q) begin
         elapsed_q <= elapsed_q + 1'b1;
      end
   end
endmodule

// ---- verilog/dram_train_host.sv ----
// host sequencer for training, ZQ and thermal commands on one CA channel
`timescale 1ns/10ps
module dram_train_host (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   output logic                     cs,
   output logic [5:0]               ca,
   output logic                     cke
);
   import dram_ctl_pkg::*;

   // bus side state
   logic        wr_pend_q;          // write data phase follows
   logic [7:0]  waddr_q;            // address of that write
   logic [31:0] hrdata_q;           // read data, loaded at address phase
   logic        hreadyout_q;        // zero-wait slave
   logic        hresp_q;            // always OKAY
   // software registers
   logic [31:0] ctrl_q;
   logic [31:0] lat_q;
   logic [31:0] skew_q;
   logic [31:0] twin_q;
   logic [31:0] zqt_q;
   logic [31:0] poll_q;
   logic [31:0] raw_q;              // four CA words for generic commands
   logic [6:0]  cmd_q;              // pending command
   // sequencer and tracking state
   state_t      state_q;
   logic [1:0]  edge_q;             // CA edge being driven
   grp_t        prev_q;             // group of last data command
   logic        cs_q;
   logic [5:0]  ca_q;
   logic        cke_q;
   logic        zq_started_q;       // start issued, latch not yet
   logic        armed_q;            // write-FIFO done, read-FIFO pending
   logic [2:0]  wr_cnt_q;           // FIFO entries written
   logic [2:0]  rd_ptr_q;           // FIFO entry read next
   logic        refused_q;          // sticky: command dropped
   logic        undef_q;            // sticky: unwritten entry read
   logic        poll_due_q;         // sticky: temperature poll is due
   // timer outputs
   logic [TIMER_W-1:0] data_el;
   logic [TIMER_W-1:0] zqs_el;
   logic [TIMER_W-1:0] zql_el;
   logic [POLL_W-1:0]  poll_el;

   // ---------------- bus decode ----------------
   wire addr_ok = hsel & htrans[1] & hready;
   wire [7:0] raddr = haddr[7:0];
   wire wr_ctrl = wr_pend_q & (waddr_q == OFF_CTRL);
   wire wr_lat  = wr_pend_q & (waddr_q == OFF_LAT);
   wire wr_skew = wr_pend_q & (waddr_q == OFF_SKEW);
   wire wr_twin = wr_pend_q & (waddr_q == OFF_TWIN);
   wire wr_zqt  = wr_pend_q & (waddr_q == OFF_ZQT);
   wire wr_poll = wr_pend_q & (waddr_q == OFF_POLL);
   wire wr_raw  = wr_pend_q & (waddr_q == OFF_RAW);
   wire wr_cmd  = wr_pend_q & (waddr_q == OFF_CMD);
   wire wr_stat = wr_pend_q & (waddr_q == OFF_STAT);

   // ---------------- field extraction ----------------
   wire [9:0] rl     = {4'h0, lat_q[LAT_RL_LSB +: 6]};
   wire [9:0] wl     = {4'h0, lat_q[LAT_WL_LSB +: 6]};
   wire [9:0] bl2    = {5'h00, lat_q[LAT_BL2_LSB +: 5]};
   wire [9:0] tccd   = {5'h00, lat_q[LAT_CCD_LSB +: 5]};
   wire [9:0] dqss   = {6'h00, skew_q[SK_DQSS_LSB +: 4]};
   wire [9:0] dqsck  = {6'h00, skew_q[SK_DQSCK_LSB +: 4]};
   wire [9:0] rpst   = {6'h00, skew_q[SK_RPST_LSB +: 4]};
   wire [9:0] wpre   = {6'h00, skew_q[SK_WPRE_LSB +: 4]};
   wire [9:0] odtlon = {4'h0, skew_q[SK_ODTL_LSB +: 6]};
   wire [9:0] odton  = {6'h00, skew_q[SK_ODTN_LSB +: 4]};
   wire [9:0] t75    = {2'b00, twin_q[TW_T75_LSB +: 8]};
   wire [9:0] twtr   = {2'b00, twin_q[TW_WTR_LSB +: 8]};
   wire [TIMER_W-1:0] tzqcal = zqt_q[ZQ_CAL_LSB +: 16];
   wire [TIMER_W-1:0] tzqlat = zqt_q[ZQ_LAT_LSB +: 16];
   wire odt_off = (ctrl_q[CTRL_ODT_LSB +: 3] == 3'b000);

   // ---------------- spacing figures ----------------
   // larger of rounded 7.5 ns and 8 cycles
   wire [9:0] f8 = (t75 > MIN_8NCK) ? t75 : MIN_8NCK;
   wire [9:0] t_wrwtr = wl + bl2 + dqss + f8;
   wire [9:0] t_rtrrd = rl + dqsck + bl2 + rpst + f8;
   wire [9:0] t_wr_rd = wl + dqss + bl2 + twtr;
   // read-FIFO to write-FIFO: both forms clamp at zero
   wire [9:0] rtw_a  = rl + dqsck + bl2 + wpre + rpst;
   wire [9:0] rtw_b  = rl + dqsck + bl2 + rpst + 10'h001;
   wire [9:0] rtw_bs = odtlon + odton;
   wire [9:0] t_rtw_off = (rtw_a > wl) ? rtw_a - wl : 10'h000;
   wire [9:0] t_rtw_on  = (rtw_b > rtw_bs) ? rtw_b - rtw_bs : 10'h000;
   wire [9:0] t_rtw = odt_off ? t_rtw_off : t_rtw_on;

   // ---------------- pending command decode ----------------
   wire cmd_class_t cls = cmd_class_t'(cmd_q[CMD_CLS_LSB +: 4]);
   wire grp_t nxt = (cls == CLS_WR || cls == CLS_MWR) ? G_WR :
                    (cls == CLS_RD || cls == CLS_MRR) ? G_RD :
                    (cls == CLS_WRFIFO) ? G_WF :
                    (cls == CLS_RDFIFO) ? G_RF :
                    (cls == CLS_RDDQ)   ? G_RDQ : G_NONE;
   wire is_zq  = (cls == CLS_ZQSTART) | (cls == CLS_ZQLATCH);
   wire is_mpc = is_zq | (nxt == G_WF) | (nxt == G_RF) | (nxt == G_RDQ);
   // multi-purpose operand for the pending class
   wire [6:0] op = (cls == CLS_RDFIFO)  ? OP_RDFIFO :
                   (cls == CLS_RDDQ)    ? OP_RDDQ :
                   (cls == CLS_WRFIFO)  ? OP_WRFIFO :
                   (cls == CLS_ZQSTART) ? OP_ZQSTART :
                   OP_ZQLATCH;
   // ZQ commands and short generic ones take two edges, the rest four
   wire short_cmd = is_zq | (~is_mpc & cmd_q[CMD_SHORT]);
   wire [1:0] last_edge = short_cmd ? 2'd1 : 2'd3;

   // ---------------- pair table ----------------
   wire prev_rdish = (prev_q == G_RD) | (prev_q == G_RF) | (prev_q == G_RDQ);
   wire prev_wrish = (prev_q == G_WR) | (prev_q == G_WF);
   // orderings that may never occur back to back
   wire pair_forbid = ((nxt == G_RF) & ((prev_q == G_WR) |
                       (prev_q == G_RD) | (prev_q == G_RDQ))) |
                      ((prev_q == G_WF) & ((nxt == G_WR) |
                       (nxt == G_RD) | (nxt == G_RDQ)));
   // least spacing for the pair, counted from the previous issue
   wire same_train = ((prev_q == G_WF) & (nxt == G_WF)) |
                     ((prev_q == G_RF) & (nxt == G_RF)) |
                     ((prev_q == G_RDQ) & (nxt == G_RDQ));
   wire rd_plain = (prev_q == G_RD) & ((nxt == G_RD) | (nxt == G_WR));
   wire [9:0] pair_min =
      ((prev_q == G_WR) & (nxt == G_WF))  ? t_wrwtr :
      ((prev_q == G_WR) & (nxt == G_RDQ)) ? t_wr_rd :
      ((prev_q == G_WF) & (nxt == G_RF))  ? t_wr_rd :
      same_train                          ? tccd :
      ((prev_q == G_RF) & (nxt == G_WF))  ? t_rtw :
      (prev_rdish & (nxt != G_NONE) & ~rd_plain) ? t_rtrrd
                                          : 10'h000;

   // ---------------- admission checks ----------------
   wire zqcal_done = ~zq_started_q | (zqs_el >= tzqcal);
   wire zq_run = zq_started_q & ~zqcal_done;
   wire busy = (state_q != S_IDLE);
   wire cke_on = ctrl_q[CTRL_CKE];
   // only FIFO commands and training MRWs may sit between the FIFO pair
   wire armed_bad = armed_q & ~((nxt == G_WF) | (nxt == G_RF) |
                    ((cls == CLS_MRW) & cmd_q[CMD_TRAIN]));
   wire zq_bad = ((cls == CLS_ZQSTART) & ~cke_on) |
                 ((cls == CLS_ZQLATCH) & (~cke_on | ~zq_started_q));
   wire refuse = pair_forbid | armed_bad | zq_bad;
   // DQ bus quiet once the last data command has fully drained
   wire dq_idle = prev_rdish ? (data_el >= {6'h00, t_rtrrd}) :
                  prev_wrish ? (data_el >= {6'h00, t_wrwtr}) : 1'b1;
   wire spacing_ok = (data_el >= {6'h00, pair_min});
   wire zqlat_ok = (zql_el >= tzqlat);
   wire iocal_ok = ~cmd_q[CMD_IOCAL] | zqcal_done;
   wire latch_ok = (cls != CLS_ZQLATCH) | (zqcal_done & dq_idle);
   wire go = spacing_ok & zqlat_ok & iocal_ok & latch_ok;
   wire issue = (state_q == S_WAIT) & ~refuse & go;
   wire drop  = (state_q == S_WAIT) & refuse;
   wire [31:0] stat_word = {16'h0000, 1'b0, rd_ptr_q, 1'b0, wr_cnt_q,
                            2'b00, armed_q, zq_run, poll_due_q, undef_q,
                            refused_q, busy};
   wire [31:0] rdata_mux = (raddr == OFF_CTRL) ? ctrl_q :
                           (raddr == OFF_LAT)  ? lat_q  :
                           (raddr == OFF_SKEW) ? skew_q :
                           (raddr == OFF_TWIN) ? twin_q :
                           (raddr == OFF_ZQT)  ? zqt_q  :
                           (raddr == OFF_POLL) ? poll_q :
                           (raddr == OFF_CMD)  ? {25'h0, cmd_q} :
                           (raddr == OFF_RAW)  ? raw_q  :
                           (raddr == OFF_STAT) ? stat_word : 32'h0000_0000;

   // ---------------- CA word for the current edge ----------------
   wire [5:0] raw_sel = raw_q[{edge_q, 3'b000} +: 6];
   wire [5:0] mpc_ca = (edge_q == 2'd0) ? {op[6], 5'h00} :
                       (edge_q == 2'd1) ? op[5:0] :
                       (edge_q == 2'd2) ? CAS2_R1 :
                       CAS2_OPS;
   wire [5:0] edge_ca = is_mpc ? mpc_ca : raw_sel;
   wire edge_cs = ~edge_q[0];

   // ---------------- timers ----------------
   wire zq_restart = issue & (cls == CLS_ZQSTART) & zqcal_done;
   gap_timer #(.WIDTH(TIMER_W)) u_data_t (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .restart   (issue & (nxt != G_NONE)),
      .elapsed_q (data_el)
   );
   gap_timer #(.WIDTH(TIMER_W)) u_zqs_t (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .restart   (zq_restart),
      .elapsed_q (zqs_el)
   );
   gap_timer #(.WIDTH(TIMER_W)) u_zql_t (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .restart   (issue & (cls == CLS_ZQLATCH)),
      .elapsed_q (zql_el)
   );
   gap_timer #(.WIDTH(POLL_W)) u_poll_t (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .restart   (issue & (cls == CLS_MRR)),
      .elapsed_q (poll_el)
   );

   // ---------------- bus slave ----------------
   // read data loaded at address phase so it stands from a flop
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_pend_q   <= 1'b0;
         waddr_q     <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            waddr_q <= raddr;
         end
         if (addr_ok & ~hwrite) begin
            hrdata_q <= rdata_mux;
         end
      end
   end

   // configuration registers written from the data phase
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= RST_CTRL;
         lat_q  <= RST_LAT;
         skew_q <= RST_SKEW;
         twin_q <= RST_TWIN;
         zqt_q  <= RST_ZQT;
         poll_q <= RST_POLL;
         raw_q  <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl_q <= hwdata;
         if (wr_lat)  lat_q  <= hwdata;
         if (wr_skew) skew_q <= hwdata;
         if (wr_twin) twin_q <= hwdata;
         if (wr_zqt)  zqt_q  <= hwdata;
         if (wr_poll) poll_q <= hwdata;
         if (wr_raw)  raw_q  <= hwdata;
      end
   end

   // ---------------- sequencer ----------------
   // a command write while busy is dropped and flagged
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         cmd_q   <= 7'h00;
         edge_q  <= 2'd0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (wr_cmd) begin
                  cmd_q   <= hwdata[6:0];
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (drop) begin
                  state_q <= S_IDLE;
               end else if (issue) begin
                  edge_q  <= 2'd0;
                  state_q <= S_SEND;
               end
            end
            S_SEND: begin
               edge_q <= edge_q + 2'd1;
               if (edge_q == last_edge) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // CA pins: deselect outside a command, one word per edge inside
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_q  <= 1'b0;
         ca_q  <= 6'h00;
         cke_q <= 1'b0;
      end else begin
         cs_q  <= (state_q == S_SEND) & edge_cs;
         ca_q  <= (state_q == S_SEND) ? edge_ca : 6'h00;
         cke_q <= cke_on;
      end
   end

   // ---------------- tracking of the device state ----------------
   wire disturb = issue & ((nxt == G_WR) | (nxt == G_RD) | (nxt == G_RDQ));
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prev_q       <= G_NONE;
         zq_started_q <= 1'b0;
         armed_q      <= 1'b0;
         wr_cnt_q     <= 3'h0;
         rd_ptr_q     <= 3'h0;
      end else begin
         if (issue & (nxt != G_NONE)) begin
            prev_q <= nxt;
         end
         if (issue & (cls == CLS_ZQSTART)) begin
            zq_started_q <= 1'b1;
         end else if (issue & (cls == CLS_ZQLATCH)) begin
            zq_started_q <= 1'b0;
         end
         if (disturb | ~cke_on) begin
            // these commands and power-down upset the FIFO pointers
            armed_q  <= 1'b0;
            wr_cnt_q <= 3'h0;
            rd_ptr_q <= 3'h0;
         end else if (issue & (nxt == G_WF)) begin
            armed_q  <= 1'b1;
            rd_ptr_q <= 3'h0;
            if (wr_cnt_q != FIFO_DEPTH) begin
               wr_cnt_q <= wr_cnt_q + 3'h1;
            end
         end else if (issue & (nxt == G_RF)) begin
            armed_q  <= 1'b0;
            rd_ptr_q <= (rd_ptr_q == FIFO_DEPTH - 3'h1) ? 3'h0 :
                        rd_ptr_q + 3'h1;
         end
      end
   end

   // sticky status; a set in the cycle of a clear wins
   wire undef_set = issue & (nxt == G_RF) & (rd_ptr_q >= wr_cnt_q);
   wire poll_set = (poll_q != 32'h0000_0000) & (poll_el >= poll_q);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         refused_q  <= 1'b0;
         undef_q    <= 1'b0;
         poll_due_q <= 1'b0;
      end else begin
         if (drop | (wr_cmd & busy)) begin
            refused_q <= 1'b1;
         end else if (wr_stat & hwdata[SB_REFUSED]) begin
            refused_q <= 1'b0;
         end
         if (undef_set) begin
            undef_q <= 1'b1;
         end else if (wr_stat & hwdata[SB_UNDEF]) begin
            undef_q <= 1'b0;
         end
         if (poll_set) begin
            poll_due_q <= 1'b1;
         end else if (wr_stat & hwdata[SB_POLL]) begin
            poll_due_q <= 1'b0;
         end
      end
   end

   // outputs straight from flops
   assign hreadyout = hreadyout_q;
   assign hrdata    = hrdata_q;
   assign hresp     = hresp_q;
   assign cs        = cs_q;
   assign ca        = ca_q;
   assign cke       = cke_q;
endmodule

// ---- verif/dram_train_host_properties.sv ----
// assertion checker for the training and calibration host
`timescale 1ns/10ps
module host_checker (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       cs,
   input wire logic [5:0] ca,
   input wire logic       cke
);
   logic       mpc_q;     // last edge was an MPC first edge
   logic [7:0] rf_gap_q;  // cycles since last read-FIFO
   logic [7:0] wf_gap_q;  // cycles since last write-FIFO
   wire        sec    = mpc_q & !cs;
   wire        rf_now = sec & (ca == 6'h01);
   wire        wf_now = sec & (ca == 6'h07);
   wire        cas2   = cs & (ca == 6'h12);
   wire        idle   = !cs & (ca == 6'h00);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // gap counters saturate, so no hold-off right after reset
   always_ff @(posedge ref_clk) begin
      mpc_q <= rst_n & cs & (ca == 6'h20);
      if (!rst_n || rf_now) rf_gap_q <= rst_n ? 8'h00 : 8'hFF;
      else if (rf_gap_q != 8'hFF) rf_gap_q <= rf_gap_q + 8'h01;
      if (!rst_n || wf_now) wf_gap_q <= rst_n ? 8'h00 : 8'hFF;
      else if (wf_gap_q != 8'hFF) wf_gap_q <= wf_gap_q + 8'h01;
   end
   ops_low_a: assert property (
      sec && ca inside {6'h01, 6'h03, 6'h07} |=> cas2 ##1 idle)
      else $error("bad CAS-2 after training command");
   zq_cke_a: assert property (sec && ca == 6'h0F |-> cke)
      else $error("ZQ start with clock enable low");
   latch_quiet_a: assert property (
      sec && ca == 6'h11 |=> !cs [*6])
      else $error("command inside ZQ latch window");
   rf_ccd_a: assert property (rf_now |-> rf_gap_q >= 8'h07)
      else $error("read-FIFO closer than tCCD");
   wf_rf_a: assert property (rf_now |-> wf_gap_q >= 8'h18)
      else $error("read-FIFO too soon after write-FIFO");
   cs_pulse_a: assert property (cs |=> !cs)
      else $error("select held two cycles");
   idle_ca_a: assert property (
      !cs && !$past(cs) |-> ca == 6'h00)
      else $error("CA not quiet when deselected");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus stalled or errored");
   cover property (rf_now);
   cover property (sec && ca == 6'h11);
   cover property (sec && ca == 6'h0F);
endmodule
bind dram_train_host host_checker u_host_checker (.ref_clk(ref_clk),
   .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .cs(cs),
   .ca(ca), .cke(cke));

// ---- verif/dram_dev_model.sv ----
// behavioural device that decodes multi-purpose commands on CA
`timescale 1ns/10ps
module dram_dev_model (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       cs,
   input wire logic       cke,
   input wire logic [5:0] ca,
   output logic [2:0]     rd_ptr,
   output int             zq_starts,
   output int             zq_latches
);
   logic first_q;  // training MPC first edge seen
   int   zq_left;  // background calibration cycles left
   wire  sec = first_q & !cs;
   // decode second edge, wrap the pointer, run calibration
   always_ff @(posedge ref_clk) begin
      first_q <= cs & cke & (ca == 6'h20);
      if (!rst_n) begin
         rd_ptr <= 3'h0;
         zq_starts <= 0;
         zq_latches <= 0;
         zq_left <= 0;
      end else if (sec && ca == 6'h01)
         rd_ptr <= (rd_ptr == 3'h4) ? 3'h0 : rd_ptr + 3'h1;
      else if (sec && ca == 6'h07)
         rd_ptr <= 3'h0;
      else if (sec && ca == 6'h0F && zq_left == 0) begin
         zq_starts <= zq_starts + 1;
         zq_left <= 32'h0000_00C8;
      end else if (sec && ca == 6'h11)
         zq_latches <= zq_latches + 1;
      else if (zq_left != 0)
         zq_left <= zq_left - 1;
   end
endmodule

// ---- verif/dram_train_host_test.sv ----
// self-checking bench for the training and calibration host
`timescale 1ns/10ps
module dram_train_host_test;
   import dram_ctl_pkg::*;
   logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, cs, cke;
   logic [31:0] haddr, hwdata, hrdata, r, d;
   logic [1:0]  htrans;
   logic [5:0]  ca;
   logic [2:0]  rd_ptr;
   int          err_total, checks, zq_starts, zq_latches, seed, i, n;
   dram_train_host u_dram_train_host (.ref_clk(ref_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cs(cs),
      .ca(ca), .cke(cke));
   dram_dev_model u_dram_dev_model (.ref_clk(ref_clk), .rst_n(rst_n),
      .cs(cs), .cke(cke), .ca(ca), .rd_ptr(rd_ptr),
      .zq_starts(zq_starts), .zq_latches(zq_latches));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // single word transfer, read data left in r
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // post a command, then poll status until not busy
   task cmd(input cmd_class_t c);
      xfer(1'b1, OFF_CMD, {28'h0, c});
      i = 0;
      do begin
         xfer(1'b0, OFF_STAT, 32'h0);
         i++;
      end while (r[SB_BUSY] !== 1'b0 && i < 3000);
      chk(32'(r[SB_BUSY]), 32'h0);
   endtask
   function automatic logic [31:0] ptr_exp(input int k);
      return 32'(k % 5);
   endfunction
   task report_and_stop;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      report_and_stop;
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, rst_n} = '0;
      seed = 32'h896C;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      xfer(1'b0, OFF_LAT, 32'h0);
      chk(r, RST_LAT);
      chk(32'(cke), 32'h1);
      xfer(1'b0, 8'h40, 32'h0);
      chk(r, 32'h0);
      d = $random(seed);
      xfer(1'b1, OFF_POLL, d);
      xfer(1'b0, OFF_POLL, 32'h0);
      chk(r, d);
      xfer(1'b1, OFF_RAW, $random(seed) & 32'h1F1F1F1F);
      // generic MRW from raw words, as a thermal offset or ZQ reset goes
      cmd(CLS_MRW);
      chk(r & 32'h2, 32'h0);
      chk(r & 32'h8, (d != 32'h0) ? 32'h8 : 32'h0);
      cmd(CLS_RD);
      cmd(CLS_RDFIFO);
      chk(r & 32'h2, 32'h2);
      xfer(1'b1, OFF_STAT, 32'h6);
      cmd(CLS_WRFIFO);
      for (n = 1; n <= 6; n++) begin
         cmd(CLS_RDFIFO);
         chk(32'(rd_ptr), ptr_exp(n));
      end
      chk((r >> 12) & 32'h7, ptr_exp(6));
      chk(r & 32'h4, 32'h4);
      cmd(CLS_ZQSTART);
      cmd(CLS_ZQSTART);
      cmd(CLS_ZQLATCH);
      chk(32'(zq_starts), 32'h1);
      chk(32'(zq_latches), 32'h1);
      xfer(1'b1, OFF_CTRL, 32'h0);
      cmd(CLS_ZQSTART);
      chk(r & 32'h2, 32'h2);
      chk(32'(cke), 32'h0);
      report_and_stop;
   end
endmodule
